/* File: core/ccr_consts.vh */
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH
// data-space addresses of the mapped core registers
`define CCR_ADDR_INDEX_FIRST 8'h80
`define CCR_ADDR_INDEX_SECOND 8'h81
`define CCR_ADDR_SHORT_FIRST 8'h82
`define CCR_ADDR_SHORT_SECOND 8'h83
`define CCR_ADDR_ACCUMULATOR 8'hFF
// program counter and stack geometry
`define CCR_PC_WIDTH 12
`define CCR_STACK_DEPTH 6
`define CCR_PC_RESET 12'h000
`define CCR_RESET_VECTOR 12'hFFE
// short-direct access length in cpu cycles
`define CCR_SHORT_DIRECT_CYCLES 4
// context codes (one-hot)
`define CCR_CTX_NORMAL 3'h1
`define CCR_CTX_IRQ 3'h2
`define CCR_CTX_NMI 3'h4
// program counter operation codes
`define CCR_PCOP_HOLD 3'h0
`define CCR_PCOP_INC 3'h1
`define CCR_PCOP_JUMP 3'h2
`define CCR_PCOP_CALL 3'h3
`define CCR_PCOP_REL 3'h4
`define CCR_PCOP_RET 3'h5
`define CCR_PCOP_IRQ 3'h6
`define CCR_PCOP_NMI 3'h7
// flag operation codes
`define CCR_FOP_NONE 2'h0
`define CCR_FOP_ARITH 2'h1
`define CCR_FOP_LOGIC 2'h2
`define CCR_FOP_CARRY 2'h3
`endif

/* File: core/ccr_ret_stack.v */
`timescale 1ns/1ps
`include "ccr_consts.vh"
// six-level shift stack of return addresses
module ccr_ret_stack
#(
  parameter WIDTH = `CCR_PC_WIDTH,
  parameter DEPTH = `CCR_STACK_DEPTH
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // control
  input wire push_i,
  input wire pop_i,
  input wire [WIDTH-1:0] push_data_i,
  // state
  output wire [WIDTH-1:0] top_o,
  output wire empty_o,
  output wire full_o
);
  reg [WIDTH-1:0] level_reg [0:DEPTH-1];
  reg [3:0] fill_reg;
  integer i;
  //////////////////////////////////////////////////////////////////////////////
  // shift levels down on push, up on pop
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        level_reg[i] <= {WIDTH{1'b0}};
      fill_reg <= 4'h0;
    end
    else if (push_i)
    begin
      for (i = DEPTH - 1; i > 0; i = i - 1)
        level_reg[i] <= level_reg[i-1];
      level_reg[0] <= push_data_i;
      if (fill_reg != DEPTH[3:0])
        fill_reg <= fill_reg + 4'h1;
    end
    else if (pop_i && fill_reg != 4'h0)
    begin
      for (i = 0; i < DEPTH - 1; i = i + 1)
        level_reg[i] <= level_reg[i+1];
      fill_reg <= fill_reg - 4'h1;
    end
  end
  assign top_o = level_reg[0];
  assign empty_o = (fill_reg == 4'h0);
  assign full_o = (fill_reg == DEPTH[3:0]);
endmodule // ccr_ret_stack

/* File: core/ccr_core_regs.v */
`timescale 1ns/1ps
`include "ccr_consts.vh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// - accumulator read/write at data address FFh like any location
// - first index at 80h, second index at 81h
// - first short-direct at 82h, second at 83h
// - short-direct access is one byte, four cpu cycles
// - index registers also usable as short-direct operands
// - program counter is 12 bits, addresses 4096 bytes
// - pc increments after fetch; relative branch adds signed offset
// - pc loaded by jump, call, interrupt, reset, return pops
// - three carry/zero pairs: normal, irq, nmi
// - interrupt entry selects its pair; interrupt return restores previous
// - context switch never clears any flag pair
// - instructions touch only the active context's flag pair
// - carry from arithmetic carry/borrow, bit test, rotate left
// - zero set when latest arithmetic/logic result is zero
// - reset starts in nmi context with its flags
// - six 12-bit stack levels, no visible stack pointer
// - call/interrupt shifts levels down, pc enters top
// - return loads pc from top, lower levels move up
// - beyond six nestings stack stays deepest, oldest lost
// - return on empty stack leaves stack, execution continues
// - only pc saved on stack, no data registers
module ccr_core_regs
#(
  parameter PC_BITS = `CCR_PC_WIDTH,
  parameter DEPTH = `CCR_STACK_DEPTH
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // cpu cycle enable
  input wire cpu_cycle_i,
  // data-space bus
  input wire [7:0] data_addr_i,
  input wire [7:0] data_wdata_i,
  input wire data_we_i,
  input wire data_re_i,
  output reg [7:0] data_rdata_o,
  output reg data_hit_o,
  // short-direct operand select (0..3 = index1, index2, short1, short2)
  input wire short_sel_valid_i,
  input wire [1:0] short_sel_i,
  output reg short_done_o,
  // program memory fetch
  input wire fetch_i,
  input wire [7:0] prog_data_i,
  output reg [PC_BITS-1:0] program_counter_o,
  // program counter operations
  input wire [2:0] pc_op_i,
  input wire [PC_BITS-1:0] pc_target_i,
  input wire [7:0] rel_offset_i,
  input wire [PC_BITS-1:0] irq_vector_i,
  input wire [PC_BITS-1:0] nmi_vector_i,
  // flag updates from the alu
  input wire [1:0] flag_op_i,
  input wire [7:0] alu_result_i,
  input wire alu_carry_i,
  // active context state
  output reg [2:0] context_o,
  output reg carry_o,
  output reg zero_o,
  output reg stack_empty_o,
  output reg stack_full_o,
  output reg vector_ready_o
);
  // one-hot boot states
  localparam ST_VEC_LO = 3'b001;
  localparam ST_VEC_HI = 3'b010;
  localparam ST_RUN = 3'b100;
  reg [2:0] state_reg;
  reg [7:0] vec_lo_reg;
  reg [7:0] accumulator_reg;
  reg [7:0] index_first_reg;
  reg [7:0] index_second_reg;
  reg [7:0] short_direct_first_reg;
  reg [7:0] short_direct_second_reg;
  reg [PC_BITS-1:0] pc_reg;
  reg [PC_BITS-1:0] pc_next;
  reg normal_carry_reg;
  reg normal_zero_reg;
  reg irq_carry_reg;
  reg irq_zero_reg;
  reg nonmaskable_carry_reg;
  reg nonmaskable_zero_reg;
  reg [2:0] ctx_reg;
  reg [2:0] ctx_next;
  reg [2:0] ctx_saved_reg;
  reg [2:0] short_cnt_reg;
  reg carry_next;
  reg zero_next;
  reg active_carry;
  reg active_zero;
  wire run;
  wire push;
  wire pop;
  wire [PC_BITS-1:0] stack_top;
  wire stack_empty;
  wire stack_full;
  wire [PC_BITS-1:0] rel_ext;
  //////////////////////////////////////////////////////////////////////////////
  // return stack: only pc is pushed
  assign run = (state_reg == ST_RUN) && cpu_cycle_i;
  assign push = run && (pc_op_i == `CCR_PCOP_CALL || pc_op_i == `CCR_PCOP_IRQ ||
    pc_op_i == `CCR_PCOP_NMI);
  assign pop = run && (pc_op_i == `CCR_PCOP_RET);
  assign rel_ext = {{(PC_BITS-8){rel_offset_i[7]}}, rel_offset_i};
  ccr_ret_stack #(.WIDTH(PC_BITS), .DEPTH(DEPTH)) u_stack
  (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .push_i(push),
    .pop_i(pop),
    .push_data_i(pc_reg),
    .top_o(stack_top),
    .empty_o(stack_empty),
    .full_o(stack_full)
  );
  //////////////////////////////////////////////////////////////////////////////
  // program counter next value
  always @*
  begin
    pc_next = pc_reg;
    case (pc_op_i)
      `CCR_PCOP_INC: pc_next = pc_reg + {{(PC_BITS-1){1'b0}}, 1'b1};
      `CCR_PCOP_JUMP: pc_next = pc_target_i;
      `CCR_PCOP_CALL: pc_next = pc_target_i;
      `CCR_PCOP_REL: pc_next = pc_reg + rel_ext;
      `CCR_PCOP_RET:
      begin
        if (!stack_empty)
          pc_next = stack_top;
        else
          pc_next = pc_reg;
      end
      `CCR_PCOP_IRQ: pc_next = irq_vector_i;
      `CCR_PCOP_NMI: pc_next = nmi_vector_i;
      default: pc_next = pc_reg;
    endcase
    if (fetch_i && pc_op_i == `CCR_PCOP_HOLD)
      pc_next = pc_reg + {{(PC_BITS-1){1'b0}}, 1'b1};
  end
  //////////////////////////////////////////////////////////////////////////////
  // reset vector fetch then run
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg <= ST_VEC_LO;
      vec_lo_reg <= 8'h00;
      pc_reg <= `CCR_RESET_VECTOR;
    end
    else if (cpu_cycle_i)
    begin
      case (state_reg)
        ST_VEC_LO:
        begin
          vec_lo_reg <= prog_data_i;
          pc_reg <= `CCR_RESET_VECTOR + 12'h001;
          state_reg <= ST_VEC_HI;
        end
        ST_VEC_HI:
        begin
          pc_reg <= {prog_data_i[PC_BITS-9:0], vec_lo_reg};
          state_reg <= ST_RUN;
        end
        ST_RUN: pc_reg <= pc_next;
        default: state_reg <= ST_VEC_LO;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // context selection
  always @*
  begin
    ctx_next = ctx_reg;
    if (pc_op_i == `CCR_PCOP_NMI)
      ctx_next = `CCR_CTX_NMI;
    else if (pc_op_i == `CCR_PCOP_IRQ)
      ctx_next = `CCR_CTX_IRQ;
  end
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctx_reg <= `CCR_CTX_NMI;
      ctx_saved_reg <= `CCR_CTX_NORMAL;
    end
    else if (run)
    begin
      if (pc_op_i == `CCR_PCOP_IRQ || pc_op_i == `CCR_PCOP_NMI)
      begin
        ctx_saved_reg <= ctx_reg;
        ctx_reg <= ctx_next;
      end
      else if (pc_op_i == `CCR_PCOP_RET && ctx_reg != `CCR_CTX_NORMAL && pc_target_i[0])
      begin
        // interrupt return flagged by target bit 0
        ctx_reg <= ctx_saved_reg;
        ctx_saved_reg <= `CCR_CTX_NORMAL;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // flag computation for active pair
  always @*
  begin
    // live pair of the current context, not the one-clock-late outputs
    active_carry = (ctx_reg == `CCR_CTX_NORMAL) ? normal_carry_reg :
      (ctx_reg == `CCR_CTX_IRQ) ? irq_carry_reg : nonmaskable_carry_reg;
    active_zero = (ctx_reg == `CCR_CTX_NORMAL) ? normal_zero_reg :
      (ctx_reg == `CCR_CTX_IRQ) ? irq_zero_reg : nonmaskable_zero_reg;
    carry_next = active_carry;
    zero_next = active_zero;
    case (flag_op_i)
      `CCR_FOP_ARITH:
      begin
        carry_next = alu_carry_i;
        zero_next = (alu_result_i == 8'h00);
      end
      `CCR_FOP_LOGIC: zero_next = (alu_result_i == 8'h00);
      `CCR_FOP_CARRY: carry_next = alu_carry_i;
      default: carry_next = active_carry;
    endcase
  end
  // three pairs, never cleared on switch
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      normal_carry_reg <= 1'b0;
      normal_zero_reg <= 1'b0;
      irq_carry_reg <= 1'b0;
      irq_zero_reg <= 1'b0;
      nonmaskable_carry_reg <= 1'b0;
      nonmaskable_zero_reg <= 1'b0;
    end
    else if (run && flag_op_i != `CCR_FOP_NONE)
    begin
      case (ctx_reg)
        `CCR_CTX_NORMAL:
        begin
          normal_carry_reg <= carry_next;
          normal_zero_reg <= zero_next;
        end
        `CCR_CTX_IRQ:
        begin
          irq_carry_reg <= carry_next;
          irq_zero_reg <= zero_next;
        end
        default:
        begin
          nonmaskable_carry_reg <= carry_next;
          nonmaskable_zero_reg <= zero_next;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // data-space mapped registers
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      accumulator_reg <= 8'h00;
      index_first_reg <= 8'h00;
      index_second_reg <= 8'h00;
      short_direct_first_reg <= 8'h00;
      short_direct_second_reg <= 8'h00;
    end
    else if (data_we_i)
    begin
      case (data_addr_i)
        `CCR_ADDR_ACCUMULATOR: accumulator_reg <= data_wdata_i;
        `CCR_ADDR_INDEX_FIRST: index_first_reg <= data_wdata_i;
        `CCR_ADDR_INDEX_SECOND: index_second_reg <= data_wdata_i;
        `CCR_ADDR_SHORT_FIRST: short_direct_first_reg <= data_wdata_i;
        `CCR_ADDR_SHORT_SECOND: short_direct_second_reg <= data_wdata_i;
        default: accumulator_reg <= accumulator_reg;
      endcase
    end
  end
  // registered read data and hit
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      data_rdata_o <= 8'h00;
      data_hit_o <= 1'b0;
    end
    else
    begin
      data_hit_o <= 1'b0;
      data_rdata_o <= 8'h00;
      if (data_re_i)
      begin
        data_hit_o <= 1'b1;
        case (data_addr_i)
          `CCR_ADDR_ACCUMULATOR: data_rdata_o <= accumulator_reg;
          `CCR_ADDR_INDEX_FIRST: data_rdata_o <= index_first_reg;
          `CCR_ADDR_INDEX_SECOND: data_rdata_o <= index_second_reg;
          `CCR_ADDR_SHORT_FIRST: data_rdata_o <= short_direct_first_reg;
          `CCR_ADDR_SHORT_SECOND: data_rdata_o <= short_direct_second_reg;
          default: data_hit_o <= 1'b0;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // short-direct access timing, all four registers eligible
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      short_cnt_reg <= 3'h0;
      short_done_o <= 1'b0;
    end
    else
    begin
      short_done_o <= 1'b0;
      if (short_cnt_reg == 3'h0)
      begin
        if (short_sel_valid_i && cpu_cycle_i)
          short_cnt_reg <= 3'h1;
      end
      else if (cpu_cycle_i)
      begin
        if (short_cnt_reg == `CCR_SHORT_DIRECT_CYCLES - 1)
        begin
          short_cnt_reg <= 3'h0;
          short_done_o <= 1'b1;
        end
        else
          short_cnt_reg <= short_cnt_reg + 3'h1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // registered status outputs
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      program_counter_o <= `CCR_RESET_VECTOR;
      context_o <= `CCR_CTX_NMI;
      carry_o <= 1'b0;
      zero_o <= 1'b0;
      stack_empty_o <= 1'b1;
      stack_full_o <= 1'b0;
      vector_ready_o <= 1'b0;
    end
    else
    begin
      program_counter_o <= pc_reg;
      context_o <= ctx_reg;
      carry_o <= active_carry;
      zero_o <= active_zero;
      stack_empty_o <= stack_empty;
      stack_full_o <= stack_full;
      vector_ready_o <= (state_reg == ST_RUN);
    end
  end
endmodule // ccr_core_regs

/* File: test/ccr_prog_mem.sv */
`timescale 1ns/1ps
// program memory: reset vector bytes first, then a changing pattern
module ccr_prog_mem
#(
  parameter VEC = 12'h123
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // fetch side
  input wire cpu_cycle_i,
  input wire [11:0] addr_i,
  output logic [7:0] data_o
);
  logic [1:0] boot_reg;
  // counts the two vector fetches after reset
  always @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
      boot_reg <= 2'h0;
    else if (cpu_cycle_i && boot_reg != 2'h2)
      boot_reg <= boot_reg + 2'h1;
  end
  // low byte, then high nibble; later bytes are the inverted low byte of the fetch address
  assign data_o = (boot_reg == 2'h0) ? VEC[7:0] : (boot_reg == 2'h1) ? {4'h0, VEC[11:8]} : ~addr_i[7:0];
endmodule // ccr_prog_mem

/* File: test/ccr_core_regs_props.sv */
`timescale 1ns/1ps
`include "ccr_consts.vh"
// port-level checks of the register core
module ccr_core_regs_props
#(
  parameter PC_BITS = 12,
  parameter DEPTH = 6
)
(
  input wire clk_sys_i,
  input wire reset_i,
  input wire cpu_cycle_i,
  input wire [7:0] data_addr_i,
  input wire [7:0] data_wdata_i,
  input wire data_we_i,
  input wire data_re_i,
  input wire [7:0] data_rdata_o,
  input wire data_hit_o,
  input wire [2:0] pc_op_i,
  input wire [PC_BITS-1:0] pc_target_i,
  input wire [1:0] flag_op_i,
  input wire [7:0] alu_result_i,
  input wire alu_carry_i,
  input wire [PC_BITS-1:0] program_counter_o,
  input wire [2:0] context_o,
  input wire carry_o,
  input wire zero_o,
  input wire stack_empty_o,
  input wire stack_full_o,
  input wire vector_ready_o
);
  // mapped data-space places
  wire mapped = data_addr_i[7:2] == 6'h20 || data_addr_i == `CCR_ADDR_ACCUMULATOR;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // a cpu cycle taking a pc operation
  sequence pc_take(logic [2:0] op);
    vector_ready_o && cpu_cycle_i && pc_op_i == op;
  endsequence
  // write, idle cycle, read of the same place
  sequence wr_rd;
    data_we_i && mapped ##1 !data_we_i ##1 data_re_i && !data_we_i && data_addr_i == $past(data_addr_i, 2);
  endsequence
  reset_ctx_a: assert property ($fell(reset_i) |-> context_o == `CCR_CTX_NMI && stack_empty_o)
    else $error("reset context wrong");
  acc_hit_a: assert property (data_re_i && data_addr_i == `CCR_ADDR_ACCUMULATOR |=> data_hit_o)
    else $error("accumulator not hit");
  reg_hit_a: assert property (data_re_i && data_addr_i[7:2] == 6'h20 |=> data_hit_o)
    else $error("index or short register not hit");
  unmapped_read_a: assert property (data_re_i && !mapped |=> !data_hit_o && data_rdata_o == 8'h00)
    else $error("unmapped read answered");
  write_read_a: assert property (wr_rd |=> data_rdata_o == $past(data_wdata_i, 3))
    else $error("read back differs");
  jump_load_a: assert property (pc_take(`CCR_PCOP_JUMP) |=> ##1 program_counter_o == $past(pc_target_i, 2))
    else $error("jump target not loaded");
  call_push_a: assert property (pc_take(`CCR_PCOP_CALL) |=> ##1 !stack_empty_o && program_counter_o == $past(pc_target_i, 2))
    else $error("call not pushed");
  irq_ctx_a: assert property (pc_take(`CCR_PCOP_IRQ) |=> ##1 context_o == `CCR_CTX_IRQ)
    else $error("irq context not selected");
  nmi_ctx_a: assert property (pc_take(`CCR_PCOP_NMI) |=> ##1 context_o == `CCR_CTX_NMI)
    else $error("nmi context not selected");
  arith_flag_a: assert property (pc_take(`CCR_PCOP_HOLD) ##0 flag_op_i == `CCR_FOP_ARITH |=> ##1
    carry_o == $past(alu_carry_i, 2) && zero_o == ($past(alu_result_i, 2) == 8'h00))
    else $error("arith flags wrong");
  full_empty_a: assert property (stack_full_o |-> !stack_empty_o)
    else $error("stack full and empty");
endmodule // ccr_core_regs_props
bind ccr_core_regs ccr_core_regs_props #(.PC_BITS(PC_BITS), .DEPTH(DEPTH)) i_props (.clk_sys_i, .reset_i, .cpu_cycle_i,
  .data_addr_i, .data_wdata_i, .data_we_i, .data_re_i, .data_rdata_o, .data_hit_o, .pc_op_i, .pc_target_i, .flag_op_i,
  .alu_result_i, .alu_carry_i, .program_counter_o, .context_o, .carry_o, .zero_o, .stack_empty_o, .stack_full_o,
  .vector_ready_o);

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "ccr_consts.vh"
module tb;
  typedef struct {logic [2:0] op; logic [11:0] tgt; logic [7:0] off; logic f; logic [11:0] pc;} ccr_row_t;
  localparam logic [11:0] VEC = 12'h123;
  logic clk_sys_i = 0, reset_i = 1, cpu_cycle_i = 0, data_we_i = 0, data_re_i = 0, fetch_i = 0, alu_carry_i = 0;
  logic short_sel_valid_i = 0, data_hit_o, short_done_o, carry_o, zero_o, stack_empty_o, stack_full_o, vector_ready_o;
  logic [7:0] data_addr_i = 0, data_wdata_i = 0, rel_offset_i = 0, alu_result_i = 0, prog_data_i, data_rdata_o;
  logic [1:0] short_sel_i = 0, flag_op_i = 0;
  logic [2:0] pc_op_i = 0, context_o;
  logic [11:0] pc_target_i = 0, irq_vector_i = 12'h300, nmi_vector_i = 12'h350, program_counter_o;
  logic [7:0] adr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
  int n_errors = 0, num_checks = 0, ticks = 0, n = 0, done_at = 0, short_from = 0;
  ccr_row_t rows [10];
  ccr_core_regs i_dut (.clk_sys_i, .reset_i, .cpu_cycle_i, .data_addr_i, .data_wdata_i, .data_we_i, .data_re_i,
    .data_rdata_o, .data_hit_o, .short_sel_valid_i, .short_sel_i, .short_done_o, .fetch_i, .prog_data_i,
    .program_counter_o, .pc_op_i, .pc_target_i, .rel_offset_i, .irq_vector_i, .nmi_vector_i, .flag_op_i,
    .alu_result_i, .alu_carry_i, .context_o, .carry_o, .zero_o, .stack_empty_o, .stack_full_o, .vector_ready_o);
  ccr_prog_mem #(.VEC(VEC)) i_mem (.clk_sys_i, .reset_i, .cpu_cycle_i, .addr_i(program_counter_o), .data_o(prog_data_i));
  // clock and hang guard
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    n <= n + cpu_cycle_i;
    ticks <= ticks + 1;
    if (ticks == 3000)
    begin
      n_errors++;
      finish_test;
    end
  end
  // first cpu-cycle count at which short access completes
  always @(negedge clk_sys_i) if (short_done_o === 1'b1 && done_at == 0) done_at = n;
  task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task chkb(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // one cpu cycle; outputs settled when it returns
  task cyc(input logic [2:0] op, input logic [11:0] tgt, input logic [7:0] off, input logic [1:0] fo, input logic [7:0] r,
    input logic c, input logic f);
    @(negedge clk_sys_i);
    {cpu_cycle_i, pc_op_i, pc_target_i, rel_offset_i, flag_op_i, alu_result_i, alu_carry_i, fetch_i} = {1'b1, op, tgt, off, fo, r, c, f};
    @(negedge clk_sys_i);
    {cpu_cycle_i, fetch_i, flag_op_i} = 4'h0;
    @(negedge clk_sys_i);
  endtask
  // one data-space access; read data settled when it returns
  task acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    {data_we_i, data_re_i, data_addr_i, data_wdata_i} = {we, !we, a, d};
    @(negedge clk_sys_i);
    {data_we_i, data_re_i} = 2'h0;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rows = '{'{`CCR_PCOP_INC, 0, 0, 0, 12'h124}, '{`CCR_PCOP_HOLD, 0, 0, 1, 12'h125}, '{`CCR_PCOP_JUMP, 12'h200, 0, 0, 12'h200},
      '{`CCR_PCOP_REL, 0, 8'h05, 0, 12'h205}, '{`CCR_PCOP_REL, 0, 8'hFD, 0, 12'h202}, '{`CCR_PCOP_CALL, 12'h400, 0, 0, 12'h400},
      '{`CCR_PCOP_CALL, 12'h500, 0, 0, 12'h500}, '{`CCR_PCOP_RET, 0, 0, 0, 12'h400}, '{`CCR_PCOP_RET, 0, 0, 0, 12'h202},
      '{`CCR_PCOP_RET, 0, 0, 0, 12'h202}};
    repeat (8) @(negedge clk_sys_i);
    chk("pc", `CCR_RESET_VECTOR, program_counter_o);
    chk("context", `CCR_CTX_NMI, context_o);
    chkb("empty", 1'b1, stack_empty_o);
    reset_i = 0;
    acc(0, `CCR_ADDR_ACCUMULATOR, 0);
    chk("acc", 12'h000, {4'h0, data_rdata_o});
    repeat (2) cyc(`CCR_PCOP_HOLD, 0, 0, 0, 0, 0, 0);
    chk("pc", VEC, program_counter_o);
    chkb("ready", 1'b1, vector_ready_o);
    $display("test reset done");
    foreach (rows[i])
    begin
      cyc(rows[i].op, rows[i].tgt, rows[i].off, 0, 0, 0, rows[i].f);
      chk("pc", rows[i].pc, program_counter_o);
    end
    chkb("empty", 1'b1, stack_empty_o);
    foreach (adr[i])
    begin
      acc(1, adr[i], 8'(8'h11 * (i + 1)));
      acc(0, adr[i], 0);
      chk("rdata", {4'h0, 8'(8'h11 * (i + 1))}, {4'h0, data_rdata_o});
      chkb("hit", 1'b1, data_hit_o);
    end
    acc(1, 8'h84, 8'hAA);
    acc(0, 8'h84, 0);
    chk("unmapped", 12'h000, {4'h0, data_rdata_o});
    chkb("hit", 1'b0, data_hit_o);
    $display("test table done");
    for (int i = 0; i < 7; i++) cyc(`CCR_PCOP_CALL, 12'h600 + i, 0, 0, 0, 0, 0);
    chkb("full", 1'b1, stack_full_o);
    acc(0, `CCR_ADDR_ACCUMULATOR, 0);
    chk("acc", 12'h055, {4'h0, data_rdata_o});
    for (int i = 0; i < 6; i++)
    begin
      cyc(`CCR_PCOP_RET, 0, 0, 0, 0, 0, 0);
      chk("pc", 12'h605 - i, program_counter_o);
    end
    cyc(`CCR_PCOP_RET, 0, 0, 0, 0, 0, 0);
    chk("pc", 12'h600, program_counter_o);
    chkb("empty", 1'b1, stack_empty_o);
    $display("test stack done");
    cyc(`CCR_PCOP_HOLD, 0, 0, `CCR_FOP_ARITH, 8'h00, 1, 0);
    chk("flags", 12'h003, {10'h0, carry_o, zero_o});
    cyc(`CCR_PCOP_IRQ, 0, 0, 0, 0, 0, 0);
    chk("context", `CCR_CTX_IRQ, context_o);
    chk("pc", 12'h300, program_counter_o);
    chk("flags", 12'h000, {10'h0, carry_o, zero_o});
    cyc(`CCR_PCOP_HOLD, 0, 0, `CCR_FOP_CARRY, 8'h00, 1, 0);
    chk("flags", 12'h002, {10'h0, carry_o, zero_o});
    cyc(`CCR_PCOP_RET, 12'h001, 0, 0, 0, 0, 0);
    chk("context", `CCR_CTX_NMI, context_o);
    chk("pc", 12'h600, program_counter_o);
    chk("flags", 12'h003, {10'h0, carry_o, zero_o});
    cyc(`CCR_PCOP_IRQ, 0, 0, 0, 0, 0, 0);
    chk("flags", 12'h002, {10'h0, carry_o, zero_o});
    cyc(`CCR_PCOP_NMI, 0, 0, 0, 0, 0, 0);
    chk("context", `CCR_CTX_NMI, context_o);
    chk("pc", 12'h350, program_counter_o);
    cyc(`CCR_PCOP_HOLD, 0, 0, `CCR_FOP_LOGIC, 8'h07, 0, 0);
    chk("flags", 12'h002, {10'h0, carry_o, zero_o});
    $display("test flags done");
    @(negedge clk_sys_i);
    {short_sel_valid_i, short_sel_i} = 3'h4;
    short_from = n;
    repeat (8)
    begin
      @(negedge clk_sys_i);
      cpu_cycle_i = 1;
      @(negedge clk_sys_i);
      {cpu_cycle_i, short_sel_valid_i} = 2'h0;
    end
    chk("short cycles", `CCR_SHORT_DIRECT_CYCLES, 12'(done_at - short_from));
    $display("test short done");
    finish_test;
  end
endmodule // tb
